// ### rtl/dual_clock_fifo_ports_flags.sv
// port control, mailboxes and synchronized flags of a two-port 2048x36 fifo
//
// Overview of operation
// R1: port a data driven only when selected low
// R2: fifo write needs select, enable, space, no mail
// R3: write and read ports never interlock
// R4: port b drives data when chip low, select high
// R5: fifo read needs select, enable, valid, no mail
// R6: enable low means no transfer that cycle
// R7: port a mail read releases b-to-a full flag
// R8: port b mail read releases a-to-b full flag
// R9: empty output register reloads automatically with valid
// R10: valid high: advance only on selected read
// R11: flags pass two stages of own port clock
// R12: flag levels follow the word count table
// R13: word in output register frees its slot
// R14: valid low: keep word, ignore reads
// R15: read pointer per load, write pointer per write
// R16: new word appears on third read edge
// R17: read edges too close to write count later
// R18: no space: ignore fifo writes
// R19: freed slot shows space after second write edge
// R20: write edges too close to read count later
// R21: near-empty low up to offset, high above
// R22: near-empty rises second read edge after write
// R23: mailbox write drops flag, blocks rewrites, persists
// R24: near-full low from depth minus offset
// R25: reset clears pointers, mail flags go high
// R26: counts come from gray pointers crossed over
`timescale 1ns/10ps
`default_nettype none

module dual_clock_fifo_ports_flags #(
  parameter int DATA_W = fifo_pkg::DATA_W,
  parameter int ADDR_W = fifo_pkg::ADDR_W
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire logic                        write_port_clock,
  input  wire logic                        read_port_clock,
  input  wire logic                        chip_sel_a_n,
  input  wire logic                        wr_rd_sel_a,
  input  wire logic                        port_a_xfer_allow,
  input  wire logic                        port_a_mail_select,
  input  wire logic [DATA_W-1:0]           port_a_data_in,
  output logic      [DATA_W-1:0]           port_a_data_out,
  output logic                             port_a_data_oe,
  input  wire logic                        chip_sel_b_n,
  input  wire logic                        wr_rd_sel_b,
  input  wire logic                        port_b_xfer_allow,
  input  wire logic                        port_b_mail_select,
  input  wire logic [DATA_W-1:0]           port_b_data_in,
  output logic      [DATA_W-1:0]           port_b_data_out,
  output logic                             port_b_data_oe,
  input  wire logic [fifo_pkg::OFS_W-1:0]  near_empty_offset,
  input  wire logic [fifo_pkg::OFS_W-1:0]  near_full_offset,
  output logic                             write_space_flag,
  output logic                             read_valid_flag,
  output logic                             near_empty_n,
  output logic                             near_full_n,
  output logic                             a_to_b_mail_full_n,
  output logic                             b_to_a_mail_full_n
);

  localparam int PW = fifo_pkg::PTR_W;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                wclk_d_r;
  logic                rclk_d_r;
  logic                wr_edge;
  logic                rd_edge;
  fifo_pkg::port_ctl_s a_ctl;
  fifo_pkg::port_ctl_s b_ctl;
  fifo_pkg::port_op_e  a_op;
  fifo_pkg::port_op_e  b_op;

  logic [PW-1:0]       wptr_r;
  logic [PW-1:0]       wgray_r;
  logic [PW-1:0]       rptr_r;
  logic [PW-1:0]       rgray_r;
  logic [PW-1:0]       pref_r;
  logic [PW-1:0]       wg_s1_r;
  logic [PW-1:0]       wg_s2_r;
  logic [PW-1:0]       rg_s1_r;
  logic [PW-1:0]       rg_s2_r;
  logic [PW-1:0]       rd_words;
  logic [PW-1:0]       wr_words;
  logic [PW-1:0]       full_mark;

  logic                fifo_wr;
  logic                mem_rd;
  logic                pend_r;
  logic [DATA_W-1:0]   mem_rdata;
  logic                buf_in_ready;
  logic                buf_out_valid;
  logic [DATA_W-1:0]   buf_out_data;
  logic                out_load;

  logic [DATA_W-1:0]   out_reg_r;
  logic [DATA_W-1:0]   a_to_b_mail_r;
  logic [DATA_W-1:0]   b_to_a_mail_r;
  logic                read_valid_r;
  logic                write_space_r;
  logic                near_empty_n_r;
  logic                near_full_n_r;
  logic                a_to_b_full_n_r;
  logic                b_to_a_full_n_r;
  logic [DATA_W-1:0]   a_out_r;
  logic [DATA_W-1:0]   b_out_r;
  logic                a_oe_r;
  logic                b_oe_r;

  // ----------------------------------------------------------------
  // port clock edges as one-cycle enables
  // ----------------------------------------------------------------
  // port clocks arrive synchronous to sys_clk, so a plain delay suffices
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wclk_d_r <= 1'b0;
      rclk_d_r <= 1'b0;
    end else begin
      wclk_d_r <= write_port_clock;
      rclk_d_r <= read_port_clock;
    end
  end

  assign wr_edge = write_port_clock && !wclk_d_r;
  assign rd_edge = read_port_clock && !rclk_d_r;

  // ----------------------------------------------------------------
  // port decode
  // ----------------------------------------------------------------
  // port b select has the opposite sense, hence the write level of 0
  assign a_ctl = '{cs_n: chip_sel_a_n, wr_rd_sel: wr_rd_sel_a,
                   xfer_allow: port_a_xfer_allow, mail_select: port_a_mail_select};
  assign b_ctl = '{cs_n: chip_sel_b_n, wr_rd_sel: wr_rd_sel_b,
                   xfer_allow: port_b_xfer_allow, mail_select: port_b_mail_select};
  assign a_op  = fifo_pkg::port_op(a_ctl, wr_edge, 1'b1); // R6
  assign b_op  = fifo_pkg::port_op(b_ctl, rd_edge, 1'b0); // R6

  // ----------------------------------------------------------------
  // write side
  // ----------------------------------------------------------------
  // writes look only at local space, never at the read port
  assign fifo_wr = (a_op == fifo_pkg::OP_FIFO_WR) && write_space_r; // R2 R3 R18

  // write pointer and its gray copy for the read side
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wptr_r  <= fifo_pkg::PTR_RST; // R25
      wgray_r <= fifo_pkg::PTR_RST;
    end else if (fifo_wr) begin
      wptr_r  <= wptr_r + 1'b1; // R15
      wgray_r <= fifo_pkg::bin2gray(wptr_r + 1'b1); // R26
    end
  end

  // ----------------------------------------------------------------
  // pointer crossings, each stepped by the receiving port's edge
  // ----------------------------------------------------------------
  // a write just before a read edge lands in stage one there, later ones wait
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wg_s1_r <= fifo_pkg::PTR_RST;
      wg_s2_r <= fifo_pkg::PTR_RST;
    end else if (rd_edge) begin
      wg_s1_r <= wgray_r; // R17
      wg_s2_r <= wg_s1_r; // R11
    end
  end

  // same two stages for the read pointer on write edges
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rg_s1_r <= fifo_pkg::PTR_RST;
      rg_s2_r <= fifo_pkg::PTR_RST;
    end else if (wr_edge) begin
      rg_s1_r <= rgray_r; // R20
      rg_s2_r <= rg_s1_r; // R11
    end
  end

  // word counts in each port's view; output register word is not counted
  assign rd_words  = fifo_pkg::gray2bin(wg_s2_r) - rptr_r; // R13 R26
  assign wr_words  = wptr_r - fifo_pkg::gray2bin(rg_s2_r); // R13 R26
  assign full_mark = fifo_pkg::FIFO_DEPTH - PW'(near_full_offset);

  // ----------------------------------------------------------------
  // write-side flags
  // ----------------------------------------------------------------
  // registered every cycle so they settle well before the next port edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      write_space_r <= fifo_pkg::WRITE_SPACE_RST;
      near_full_n_r <= fifo_pkg::NEAR_FULL_RST;
    end else begin
      write_space_r <= (wr_words != fifo_pkg::FIFO_DEPTH); // R12 R19
      near_full_n_r <= (wr_words < full_mark); // R24
    end
  end

  // ----------------------------------------------------------------
  // array and prefetch
  // ----------------------------------------------------------------
  // prefetch runs on sys_clk ahead of the read edges; the buffer slots
  // still count as occupied, so writes cannot overrun them
  assign mem_rd = (pref_r != wptr_r) && !pend_r && buf_in_ready;

  fifo_mem #(
    .WIDTH  (DATA_W),
    .ADDR_W (ADDR_W)
  ) u_mem (
    .sys_clk (sys_clk),
    .wr_en   (fifo_wr),
    .wr_addr (wptr_r[ADDR_W-1:0]),
    .wr_data (port_a_data_in),
    .rd_en   (mem_rd),
    .rd_addr (pref_r[ADDR_W-1:0]),
    .rd_data (mem_rdata)
  );

  // prefetch address and the one-cycle read in flight
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pref_r <= fifo_pkg::PTR_RST;
      pend_r <= 1'b0;
    end else begin
      pend_r <= mem_rd;
      if (mem_rd) begin
        pref_r <= pref_r + 1'b1;
      end
    end
  end

  pair_buffer #(
    .WIDTH (DATA_W),
    .DEPTH (fifo_pkg::BUF_DEPTH)
  ) u_buf (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (pend_r),
    .in_ready  (buf_in_ready),
    .in_data   (mem_rdata),
    .out_valid (buf_out_valid),
    .out_ready (out_load),
    .out_data  (buf_out_data)
  );

  // ----------------------------------------------------------------
  // output register and read-valid
  // ----------------------------------------------------------------
  // empty register loads by itself; a full one only on a selected read
  assign out_load = rd_edge && (rd_words != '0) && buf_out_valid &&
                    (!read_valid_r || (b_op == fifo_pkg::OP_FIFO_RD)); // R5 R9 R10 R14 R16

  // read pointer moves with every word entering the output register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rptr_r  <= fifo_pkg::PTR_RST; // R25
      rgray_r <= fifo_pkg::PTR_RST;
    end else if (out_load) begin
      rptr_r  <= rptr_r + 1'b1; // R15
      rgray_r <= fifo_pkg::bin2gray(rptr_r + 1'b1); // R26
    end
  end

  // read-valid drops when a selected read finds nothing behind it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      read_valid_r <= fifo_pkg::READ_VALID_RST;
    end else if (out_load) begin
      read_valid_r <= 1'b1; // R9 R16
    end else if (b_op == fifo_pkg::OP_FIFO_RD) begin
      read_valid_r <= 1'b0; // R12
    end
  end

  // previous word stays while read-valid is low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_reg_r <= fifo_pkg::DATA_RST;
    end else if (out_load) begin
      out_reg_r <= buf_out_data; // R14
    end
  end

  // near-empty compares the read-side count against its offset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      near_empty_n_r <= fifo_pkg::NEAR_EMPTY_RST;
    end else begin
      near_empty_n_r <= (rd_words > PW'(near_empty_offset)); // R21 R22
    end
  end

  // ----------------------------------------------------------------
  // mailboxes
  // ----------------------------------------------------------------
  // a write in the same cycle as the far read is dropped if the flag is low; the read raises it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      a_to_b_full_n_r <= fifo_pkg::MAIL_FULL_N_RST; // R25
    end else if ((a_op == fifo_pkg::OP_MAIL_WR) && a_to_b_full_n_r) begin
      a_to_b_full_n_r <= 1'b0; // R23
    end else if (b_op == fifo_pkg::OP_MAIL_RD) begin
      a_to_b_full_n_r <= 1'b1; // R8
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      b_to_a_full_n_r <= fifo_pkg::MAIL_FULL_N_RST; // R25
    end else if ((b_op == fifo_pkg::OP_MAIL_WR) && b_to_a_full_n_r) begin
      b_to_a_full_n_r <= 1'b0; // R23
    end else if (a_op == fifo_pkg::OP_MAIL_RD) begin
      b_to_a_full_n_r <= 1'b1; // R7
    end
  end

  // contents change only on an accepted write, never on a read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      a_to_b_mail_r <= fifo_pkg::DATA_RST;
      b_to_a_mail_r <= fifo_pkg::DATA_RST;
    end else begin
      if ((a_op == fifo_pkg::OP_MAIL_WR) && a_to_b_full_n_r) begin
        a_to_b_mail_r <= port_a_data_in; // R23
      end
      if ((b_op == fifo_pkg::OP_MAIL_WR) && b_to_a_full_n_r) begin
        b_to_a_mail_r <= port_b_data_in; // R23
      end
    end
  end

  // ----------------------------------------------------------------
  // data pins
  // ----------------------------------------------------------------
  // registered pin drive lags the selects by one sys_clk cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      a_oe_r  <= 1'b0;
      b_oe_r  <= 1'b0;
      a_out_r <= fifo_pkg::DATA_RST;
      b_out_r <= fifo_pkg::DATA_RST;
    end else begin
      a_oe_r  <= !chip_sel_a_n && !wr_rd_sel_a; // R1
      b_oe_r  <= !chip_sel_b_n && wr_rd_sel_b; // R4
      a_out_r <= b_to_a_mail_r; // R7
      b_out_r <= port_b_mail_select ? a_to_b_mail_r : out_reg_r; // R8
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign port_a_data_out    = a_out_r;
  assign port_a_data_oe     = a_oe_r;
  assign port_b_data_out    = b_out_r;
  assign port_b_data_oe     = b_oe_r;
  assign write_space_flag   = write_space_r;
  assign read_valid_flag    = read_valid_r;
  assign near_empty_n       = near_empty_n_r;
  assign near_full_n        = near_full_n_r;
  assign a_to_b_mail_full_n = a_to_b_full_n_r;
  assign b_to_a_mail_full_n = b_to_a_full_n_r;

endmodule : dual_clock_fifo_ports_flags

`default_nettype wire

// ### pkg/fifo_pkg.sv
// shared constants, types and helpers for the two-port fifo with flags
package fifo_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int          DATA_W     = 36;
  localparam int          ADDR_W     = 11;
  localparam int          PTR_W      = 12;
  localparam int          OFS_W      = 11;
  localparam logic [11:0] FIFO_DEPTH = 12'h800;
  localparam int          BUF_DEPTH  = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic              MAIL_FULL_N_RST = 1'b1;
  localparam logic              READ_VALID_RST  = 1'b0;
  localparam logic              WRITE_SPACE_RST = 1'b0;
  localparam logic              NEAR_EMPTY_RST  = 1'b0;
  localparam logic              NEAR_FULL_RST   = 1'b1;
  localparam logic [PTR_W-1:0]  PTR_RST         = 12'h000;
  localparam logic [DATA_W-1:0] DATA_RST        = 36'h0_0000_0000;

  // ----------------------------------------------------------------
  // port operations and control group
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE    = 3'b000,
    OP_FIFO_WR = 3'b001,
    OP_FIFO_RD = 3'b010,
    OP_MAIL_WR = 3'b011,
    OP_MAIL_RD = 3'b100
  } port_op_e;

  typedef struct packed {
    logic cs_n;
    logic wr_rd_sel;
    logic xfer_allow;
    logic mail_select;
  } port_ctl_s;

  // decode of one port at one of its clock edges
  function automatic port_op_e port_op(input port_ctl_s c, input logic edge_seen,
                                       input logic wr_level);
    port_op_e op;
    op = OP_NONE;
    if (edge_seen && !c.cs_n && c.xfer_allow) begin
      if (c.wr_rd_sel == wr_level) begin
        op = c.mail_select ? OP_MAIL_WR : OP_FIFO_WR;
      end else begin
        op = c.mail_select ? OP_MAIL_RD : OP_FIFO_RD;
      end
    end
    return op;
  endfunction : port_op

  function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction : bin2gray

  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b[PTR_W-1] = g[PTR_W-1];
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray2bin

endpackage : fifo_pkg

// ### rtl/fifo_mem.sv
// storage array of the fifo with a registered read port
`timescale 1ns/10ps
`default_nettype none

module fifo_mem #(
  parameter int WIDTH  = 36,
  parameter int ADDR_W = 11
) (
  input  wire logic              sys_clk,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]  wr_data,
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output var  logic [WIDTH-1:0]  rd_data
);

  logic [WIDTH-1:0] mem [2**ADDR_W];

  // no reset on the array so it maps onto block ram
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data comes out of a register
  always_ff @(posedge sys_clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : fifo_mem

`default_nettype wire

// ### rtl/pair_buffer.sv
// two-entry valid/ready buffer between the array and the output register
`timescale 1ns/10ps
`default_nettype none

module pair_buffer #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 2
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] slot_r [DEPTH];
  logic [PW-1:0]    head_r;
  logic [PW-1:0]    tail_r;
  logic [CW-1:0]    count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != CW'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = slot_r[head_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // occupancy and pointers; a full buffer holds off the source
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      head_r  <= '0;
      tail_r  <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        tail_r <= (tail_r == PW'(DEPTH - 1)) ? '0 : tail_r + 1'b1;
      end
      if (pop) begin
        head_r <= (head_r == PW'(DEPTH - 1)) ? '0 : head_r + 1'b1;
      end
      count_r <= count_r + CW'(push) - CW'(pop);
    end
  end

  // entry storage
  always_ff @(posedge sys_clk) begin
    if (push) begin
      slot_r[tail_r] <= in_data;
    end
  end

endmodule : pair_buffer

`default_nettype wire

// ### verification/port_clock_model.sv
// far-side model: free-running port clocks as sampled levels
`timescale 1ns/10ps
`default_nettype none

module port_clock_model #(
  parameter int A_HALF = 2,
  parameter int B_HALF = 3
) (
  input  wire logic sys_clk,
  output logic      write_port_clock,
  output logic      read_port_clock
);
  int a_cnt = 0, b_cnt = 0;

  // unequal rates so the two ports drift against each other
  always @(posedge sys_clk) begin
    a_cnt <= (a_cnt + 1) % (2 * A_HALF);
    b_cnt <= (b_cnt + 1) % (2 * B_HALF);
  end

  assign write_port_clock = a_cnt >= A_HALF;
  assign read_port_clock  = b_cnt >= B_HALF;
endmodule : port_clock_model
`default_nettype wire

// ### verification/dual_clock_fifo_ports_flags_checker.sv
// concurrent checks on the pins of the two-port fifo
`timescale 1ns/10ps
`default_nettype none

module dual_clock_fifo_ports_flags_checker #(
  parameter int DATA_W = 36
) (
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic              write_port_clock,
  input wire logic              read_port_clock,
  input wire logic              chip_sel_a_n,
  input wire logic              wr_rd_sel_a,
  input wire logic              port_a_xfer_allow,
  input wire logic              port_a_mail_select,
  input wire logic              chip_sel_b_n,
  input wire logic              wr_rd_sel_b,
  input wire logic              port_b_xfer_allow,
  input wire logic              port_b_mail_select,
  input wire logic [DATA_W-1:0] port_b_data_in,
  input wire logic [DATA_W-1:0] port_a_data_out,
  input wire logic              port_a_data_oe,
  input wire logic              port_b_data_oe,
  input wire logic              write_space_flag,
  input wire logic              read_valid_flag,
  input wire logic              near_empty_n,
  input wire logic              a_to_b_mail_full_n,
  input wire logic              b_to_a_mail_full_n
);
  logic a_q, b_q, a_edge, b_edge, a_sel, b_sel, a_mrd, a_mwr, b_mrd, b_mwr;

  // last port clock levels
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else begin
      a_q <= write_port_clock;
      b_q <= read_port_clock;
    end
  end

  // mailbox operations decoded at port edges
  assign a_edge = write_port_clock & ~a_q;
  assign b_edge = read_port_clock & ~b_q;
  assign a_sel = a_edge & ~chip_sel_a_n & port_a_xfer_allow & port_a_mail_select;
  assign b_sel = b_edge & ~chip_sel_b_n & port_b_xfer_allow & port_b_mail_select;
  assign a_mrd = a_sel & ~wr_rd_sel_a;
  assign a_mwr = a_sel & wr_rd_sel_a;
  assign b_mrd = b_sel & wr_rd_sel_b;
  assign b_mwr = b_sel & ~wr_rd_sel_b;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_b_put;
    b_mwr && b_to_a_mail_full_n;
  endsequence

  a_a_drive_sel: assert property (
    !$past(rst) |-> port_a_data_oe == $past(!chip_sel_a_n && !wr_rd_sel_a))
    else $error("port a drive enable wrong");
  a_b_drive_sel: assert property (
    !$past(rst) |-> port_b_data_oe == $past(!chip_sel_b_n && wr_rd_sel_b))
    else $error("port b drive enable wrong");
  a_b2a_release: assert property (
    a_mrd && !b_mwr |=> b_to_a_mail_full_n)
    else $error("b to a flag not released");
  a_a2b_release: assert property (
    b_mrd && !a_mwr |=> a_to_b_mail_full_n)
    else $error("a to b flag not released");
  a_mail_put_data: assert property (
    s_b_put |=> !b_to_a_mail_full_n ##1 port_a_data_out == $past(port_b_data_in, 2))
    else $error("b to a mail not stored");
  a_a2b_set: assert property (
    a_mwr && a_to_b_mail_full_n |=> !a_to_b_mail_full_n)
    else $error("a to b flag not set");
  a_valid_on_edge: assert property (
    $rose(read_valid_flag) |-> $past(b_edge))
    else $error("read valid rose off a read edge");
  a_empty_on_edge: assert property (
    $changed(near_empty_n) |-> $past(b_edge) || $past(b_edge, 2))
    else $error("near empty moved off a read edge");
  a_space_on_edge: assert property (
    $rose(write_space_flag) && !$past(rst, 2) |-> $past(a_edge) || $past(a_edge, 2))
    else $error("write space rose off a write edge");
endmodule : dual_clock_fifo_ports_flags_checker

bind dual_clock_fifo_ports_flags dual_clock_fifo_ports_flags_checker #(.DATA_W(DATA_W)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .write_port_clock(write_port_clock),
  .read_port_clock(read_port_clock), .chip_sel_a_n(chip_sel_a_n), .wr_rd_sel_a(wr_rd_sel_a),
  .port_a_xfer_allow(port_a_xfer_allow), .port_a_mail_select(port_a_mail_select),
  .chip_sel_b_n(chip_sel_b_n), .wr_rd_sel_b(wr_rd_sel_b), .port_b_xfer_allow(port_b_xfer_allow),
  .port_b_mail_select(port_b_mail_select), .port_b_data_in(port_b_data_in),
  .port_a_data_out(port_a_data_out), .port_a_data_oe(port_a_data_oe),
  .port_b_data_oe(port_b_data_oe), .write_space_flag(write_space_flag),
  .read_valid_flag(read_valid_flag), .near_empty_n(near_empty_n),
  .a_to_b_mail_full_n(a_to_b_mail_full_n), .b_to_a_mail_full_n(b_to_a_mail_full_n));
`default_nettype wire

// ### verification/dual_clock_fifo_ports_flags_tb.sv
// self-checking bench for the two-port fifo with flags
`timescale 1ns/10ps
`default_nettype none

module dual_clock_fifo_ports_flags_tb;
  logic                sys_clk = 1'b0;
  logic                rst = 1'b1;
  logic                wpc, rpc, a_oe, b_oe, ws, rv, ne_n, nf_n, a2b_n, b2a_n;
  logic                wq = 1'b0, rq = 1'b0;
  fifo_pkg::port_ctl_s ca = 4'h8;
  fifo_pkg::port_ctl_s cb = 4'h8;
  logic [35:0]         a_drv = 36'h0;
  logic [35:0]         b_drv = 36'h0;
  logic [35:0]         a_out, b_out;
  int                  fails = 0;
  int                  comparisons = 0;
  int                  n, i;
  logic [5:0]          rows [8] = '{6'h10, 6'h08, 6'h01, 6'h18, 6'h38, 6'h20, 6'h29, 6'h30};

  // 100 ns period
  initial forever #50 sys_clk = ~sys_clk;

  port_clock_model u_clk (.sys_clk(sys_clk), .write_port_clock(wpc), .read_port_clock(rpc));

  dual_clock_fifo_ports_flags u_dut (
    .sys_clk(sys_clk), .rst(rst), .write_port_clock(wpc), .read_port_clock(rpc),
    .chip_sel_a_n(ca.cs_n), .wr_rd_sel_a(ca.wr_rd_sel), .port_a_xfer_allow(ca.xfer_allow),
    .port_a_mail_select(ca.mail_select), .port_a_data_in(a_drv), .port_a_data_out(a_out),
    .port_a_data_oe(a_oe), .chip_sel_b_n(cb.cs_n), .wr_rd_sel_b(cb.wr_rd_sel),
    .port_b_xfer_allow(cb.xfer_allow), .port_b_mail_select(cb.mail_select),
    .port_b_data_in(b_drv), .port_b_data_out(b_out), .port_b_data_oe(b_oe),
    .near_empty_offset(11'h001), .near_full_offset(11'h002), .write_space_flag(ws),
    .read_valid_flag(rv), .near_empty_n(ne_n), .near_full_n(nf_n),
    .a_to_b_mail_full_n(a2b_n), .b_to_a_mail_full_n(b2a_n));

  // port clock levels one cycle back
  always @(posedge sys_clk) begin
    wq <= wpc;
    rq <= rpc;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [35:0] seen, input logic [35:0] want);
    comparisons++;
    if (seen !== want) begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  // hold the request until a port edge takes it, then drop the enable
  task automatic op(input logic pb, input logic [3:0] c, input logic [35:0] d);
    int k;
    @(posedge sys_clk);
    if (pb) begin
      cb <= c;
      b_drv <= d;
    end else begin
      ca <= c;
      a_drv <= d;
    end
    for (k = 0; k < 20; k++) begin
      @(posedge sys_clk);
      if (pb ? (rpc && !rq) : (wpc && !wq)) break;
    end
    if (k == 20) begin
      fails++;
      close_out();
    end
    if (pb) cb.xfer_allow <= 1'b0;
    else ca.xfer_allow <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : op

  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check({ws, rv, ne_n, nf_n, a2b_n, b2a_n, a_oe, b_oe}, 8'h9c);
    $display("reset test done");
    // drive enables per select pair
    foreach (rows[j]) begin
      @(posedge sys_clk);
      if (rows[j][5]) cb <= rows[j][4:1];
      else ca <= rows[j][4:1];
      repeat (2) @(posedge sys_clk);
      check(rows[j][5] ? b_oe : a_oe, rows[j][0]);
    end
    $display("enable table done");
    op(0, 4'h7, 36'h1_2345_6789);
    check(a2b_n, 1'b0);
    op(0, 4'h7, 36'h0_0000_00aa);
    op(1, 4'h5, 36'h0);
    check(a2b_n, 1'b0);
    check(b_out, 36'h1_2345_6789);
    op(1, 4'h7, 36'h0);
    check(a2b_n, 1'b1);
    check(b_out, 36'h1_2345_6789);
    op(1, 4'h3, 36'h9_8765_4321);
    op(0, 4'h1, 36'h0);
    check(b2a_n, 1'b0);
    check(a_out, 36'h9_8765_4321);
    op(0, 4'h3, 36'h0);
    check(b2a_n, 1'b1);
    $display("mailbox test done");
    cb <= 4'h4;
    n = 0;
    while (ws === 1'b1 && n < 2100) begin
      op(0, 4'h6, 36'(n));
      n++;
    end
    check(36'(n), 36'h801);
    check({rv, ne_n, nf_n}, 3'h6);
    check(b_out, 36'h0);
    op(0, 4'h6, 36'hf_ffff_ffff);
    op(1, 4'h6, 36'h0);
    for (n = 0; n < 60 && ws !== 1'b1; n++) @(posedge sys_clk);
    check(ws, 1'b1);
    check(b_out, 36'h1);
    // drain the rest word by word
    for (i = 2; i <= 2048; i++) begin
      op(1, 4'h6, 36'h0);
      check(b_out, 36'(i));
    end
    check({ne_n, nf_n}, 2'h1);
    op(1, 4'h6, 36'h0);
    check(rv, 1'b0);
    op(1, 4'h6, 36'h0);
    check(b_out, 36'h800);
    $display("fill and drain test done");
    close_out();
  end
endmodule : dual_clock_fifo_ports_flags_tb
`default_nettype wire
